// >>> src/monitor_cfg_pkg.sv
package monitor_cfg_pkg;

	////////////////////////////////////////////////////////////////////////
	// Register location, layout and reset value
	localparam logic [15:0] CFG_OFFSET = 16'h0029;
	localparam logic [15:0] CFG_RESET = 16'h0800;
	localparam logic [15:0] CFG_RW_MASK = 16'hdf08;
	localparam int TO_SEL_LSB = 14;
	localparam int STOP_BIT = 13;
	localparam int GAP_BIT = 12;
	localparam int VER_LSB = 10;
	localparam int TT_LSB = 8;
	localparam int HTD_BIT = 3;

	////////////////////////////////////////////////////////////////////////
	// Header data type codes per version select
	localparam logic [7:0] TYPE_VER_00 = 8'h04;
	localparam logic [7:0] TYPE_VER_01 = 8'h01;
	localparam logic [7:0] TYPE_VER_10 = 8'h02;
	localparam logic [7:0] TYPE_VER_11 = 8'h03;
	localparam logic [7:0] TYPE_NONE = 8'h00;

	////////////////////////////////////////////////////////////////////////
	// Timing, in microseconds, and conversion to clock cycles
	localparam int CLK_PERIOD_NS = 4;
	localparam int TO_US_00 = 18;
	localparam int TO_US_01 = 23;
	localparam int TO_US_10 = 82;
	localparam int TO_US_11 = 140;
	localparam int RTRT_US_00 = 61;
	localparam int RTRT_US_01 = 66;
	localparam int RTRT_US_10 = 122;
	localparam int RTRT_US_11 = 180;
	localparam int RTRT_ALLOW_US = 40;
	localparam int GAP_MIN_US = 4;
	localparam int TIMER_W = 16;

	function automatic int us_to_cycles(input int us);
		int c;
		c = (us * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction : us_to_cycles

	localparam int GAP_MIN_CYC = us_to_cycles(GAP_MIN_US);
	localparam int RTRT_ALLOW_CYC = us_to_cycles(RTRT_ALLOW_US);

	typedef enum logic [1:0] {ST_RUN, ST_DRAIN, ST_CLOSE} stop_state_t;

endpackage : monitor_cfg_pkg

// >>> src/interval_timer.sv
`timescale 1ns/1ps
module interval_timer #(
	parameter int W = 16
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic restart,
	output logic [W-1:0] count
);

	logic [W-1:0] count_reg;
	logic [W-1:0] count_next;

	// Counts cycles since the last restart, saturating at all ones
	assign count_next = restart ? '0 :
		(&count_reg) ? count_reg : count_reg + 1'b1;
	assign count = count_reg;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			count_reg <= '1;
		else
			count_reg <= count_next;
	end

endmodule : interval_timer

// >>> src/packet_monitor_config.sv
`timescale 1ns/1ps
module packet_monitor_config #(
	parameter int TO_CYC_00 = monitor_cfg_pkg::us_to_cycles(
		monitor_cfg_pkg::TO_US_00),
	parameter int TO_CYC_01 = monitor_cfg_pkg::us_to_cycles(
		monitor_cfg_pkg::TO_US_01),
	parameter int TO_CYC_10 = monitor_cfg_pkg::us_to_cycles(
		monitor_cfg_pkg::TO_US_10),
	parameter int TO_CYC_11 = monitor_cfg_pkg::us_to_cycles(
		monitor_cfg_pkg::TO_US_11),
	parameter int RTRT_CYC_00 = monitor_cfg_pkg::us_to_cycles(
		monitor_cfg_pkg::RTRT_US_00),
	parameter int RTRT_CYC_01 = monitor_cfg_pkg::us_to_cycles(
		monitor_cfg_pkg::RTRT_US_01),
	parameter int RTRT_CYC_10 = monitor_cfg_pkg::us_to_cycles(
		monitor_cfg_pkg::RTRT_US_10),
	parameter int RTRT_CYC_11 = monitor_cfg_pkg::us_to_cycles(
		monitor_cfg_pkg::RTRT_US_11)
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic host_wr,
	input wire logic host_rd,
	input wire logic [15:0] host_addr,
	input wire logic [15:0] host_wdata,
	output logic [15:0] host_rdata,
	output logic host_rdata_valid,
	input wire logic packet_recording_monitor,
	input wire logic msg_active,
	input wire logic msg_start,
	input wire logic word_parity_mid,
	input wire logic parity_word_is_command,
	input wire logic cmd_is_rtrt,
	input wire logic word_sync_mid,
	input wire logic sync_is_data,
	output logic [1:0] no_response_timeout_select,
	output logic gap_check_enable,
	output logic [1:0] time_tag_select,
	output logic header_trailer_disable,
	output logic [7:0] header_data_type,
	output logic header_type_valid,
	output logic no_response_timeout,
	output logic gap_violation,
	output logic format_error,
	output logic stop_pending,
	output logic packet_close,
	output logic packet_open
);

	localparam int TW = monitor_cfg_pkg::TIMER_W;

	////////////////////////////////////////////////////////////////////////
	// Decoding helpers
	function automatic logic [TW-1:0] timeout_limit(input logic [1:0] sel,
		input logic rtrt);
		logic [TW-1:0] lim;
		lim = '0;
		unique case ({rtrt, sel})
			3'h0: lim = TW'(TO_CYC_00);
			3'h1: lim = TW'(TO_CYC_01);
			3'h2: lim = TW'(TO_CYC_10);
			3'h3: lim = TW'(TO_CYC_11);
			3'h4: lim = TW'(RTRT_CYC_00);
			3'h5: lim = TW'(RTRT_CYC_01);
			3'h6: lim = TW'(RTRT_CYC_10);
			3'h7: lim = TW'(RTRT_CYC_11);
		endcase
		return lim;
	endfunction : timeout_limit

	function automatic logic [7:0] type_code(input logic [1:0] ver);
		logic [7:0] t;
		t = monitor_cfg_pkg::TYPE_NONE;
		unique case (ver)
			2'h0: t = monitor_cfg_pkg::TYPE_VER_00;
			2'h1: t = monitor_cfg_pkg::TYPE_VER_01;
			2'h2: t = monitor_cfg_pkg::TYPE_VER_10;
			2'h3: t = monitor_cfg_pkg::TYPE_VER_11;
		endcase
		return t;
	endfunction : type_code

	////////////////////////////////////////////////////////////////////////
	// Configuration register
	logic [15:0] cfg_reg;
	logic [15:0] cfg_next;
	logic [15:0] rdata_reg;
	logic rvalid_reg;
	wire hit = host_addr == monitor_cfg_pkg::CFG_OFFSET;
	wire cfg_write = host_wr && hit;
	wire stop_write = cfg_write && host_wdata[monitor_cfg_pkg::STOP_BIT];
	wire [1:0] to_sel = cfg_reg[monitor_cfg_pkg::TO_SEL_LSB +: 2];
	wire gap_en = cfg_reg[monitor_cfg_pkg::GAP_BIT];
	wire [1:0] ver_sel = cfg_reg[monitor_cfg_pkg::VER_LSB +: 2];
	wire htd = cfg_reg[monitor_cfg_pkg::HTD_BIT];

	// Stop bit is outside the mask, so it is never stored
	assign cfg_next = cfg_write ?
		(host_wdata & monitor_cfg_pkg::CFG_RW_MASK) : cfg_reg;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			cfg_reg <= monitor_cfg_pkg::CFG_RESET;
			rdata_reg <= '0;
			rvalid_reg <= 1'b0;
		end
		else
		begin
			cfg_reg <= cfg_next;
			rdata_reg <= (host_rd && hit) ? cfg_reg : '0;
			rvalid_reg <= host_rd;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Header data type
	logic [7:0] dtype_reg;
	logic dvalid_reg;

	// Only the header code depends on the version select
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			dtype_reg <= monitor_cfg_pkg::TYPE_NONE;
			dvalid_reg <= 1'b0;
		end
		else
		begin
			dtype_reg <= htd ? monitor_cfg_pkg::TYPE_NONE :
				type_code(ver_sel);
			dvalid_reg <= !htd;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// No-response time-out
	logic await_reg;
	logic await_rtrt_reg;
	logic timeout_reg;
	logic [TW-1:0] resp_count;
	wire resp_start = word_parity_mid && parity_word_is_command &&
		!await_reg;
	wire [TW-1:0] resp_limit = timeout_limit(to_sel, await_rtrt_reg);
	// RT-RT waits for a data sync, others for a status sync
	wire resp_end = await_reg && word_sync_mid &&
		(sync_is_data == await_rtrt_reg);
	wire resp_expire = await_reg && !resp_end &&
		resp_count >= resp_limit;

	interval_timer #(.W(TW)) resp_timer (
		.clk(clk),
		.rst(rst),
		.restart(resp_start),
		.count(resp_count)
	);

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			await_reg <= 1'b0;
			await_rtrt_reg <= 1'b0;
			timeout_reg <= 1'b0;
		end
		else
		begin
			await_reg <= resp_start || (await_reg && !resp_end && !resp_expire);
			await_rtrt_reg <= resp_start ? cmd_is_rtrt : await_rtrt_reg;
			timeout_reg <= resp_expire;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Minimum gap check
	logic prev_word_reg;
	logic gapv_reg;
	logic fmt_reg;
	logic [TW-1:0] gap_count;
	wire gap_short = gap_en && word_sync_mid && prev_word_reg &&
		gap_count < TW'(monitor_cfg_pkg::GAP_MIN_CYC);

	// Restarted at every mid-parity, read at the next mid-sync
	interval_timer #(.W(TW)) gap_timer (
		.clk(clk),
		.rst(rst),
		.restart(word_parity_mid),
		.count(gap_count)
	);

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			prev_word_reg <= 1'b0;
			gapv_reg <= 1'b0;
			fmt_reg <= 1'b0;
		end
		else
		begin
			prev_word_reg <= prev_word_reg || word_parity_mid;
			gapv_reg <= gap_short;
			fmt_reg <= gap_short || (fmt_reg && !msg_start);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Packet stop sequencing
	monitor_cfg_pkg::stop_state_t state_reg;
	monitor_cfg_pkg::stop_state_t state_next;
	logic close_reg;
	logic open_reg;
	logic pend_reg;
	wire stop_take = stop_write && packet_recording_monitor;

	always_comb
	begin
		state_next = state_reg;
		unique case (state_reg)
			monitor_cfg_pkg::ST_RUN:
				if (stop_take)
					state_next = monitor_cfg_pkg::ST_DRAIN;
			monitor_cfg_pkg::ST_DRAIN:
				if (!msg_active)
					state_next = monitor_cfg_pkg::ST_CLOSE;
			monitor_cfg_pkg::ST_CLOSE:
				state_next = monitor_cfg_pkg::ST_RUN;
			default:
				state_next = monitor_cfg_pkg::ST_RUN;
		endcase
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state_reg <= monitor_cfg_pkg::ST_RUN;
			close_reg <= 1'b0;
			open_reg <= 1'b0;
			pend_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			close_reg <= state_next == monitor_cfg_pkg::ST_CLOSE;
			open_reg <= close_reg;
			pend_reg <= state_next != monitor_cfg_pkg::ST_RUN;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs
	assign host_rdata = rdata_reg;
	assign host_rdata_valid = rvalid_reg;
	assign no_response_timeout_select = to_sel;
	assign gap_check_enable = gap_en;
	assign time_tag_select = cfg_reg[monitor_cfg_pkg::TT_LSB +: 2];
	assign header_trailer_disable = htd;
	assign header_data_type = dtype_reg;
	assign header_type_valid = dvalid_reg;
	assign no_response_timeout = timeout_reg;
	assign gap_violation = gapv_reg;
	assign format_error = fmt_reg;
	assign stop_pending = pend_reg;
	assign packet_close = close_reg;
	assign packet_open = open_reg;

	////////////////////////////////////////////////////////////////////////
	// Assertions
	a_timeout_map: assert property (@(posedge clk) disable iff (rst)
		!await_rtrt_reg && to_sel == 2'h3 |-> resp_limit == TW'(TO_CYC_11))
		else $error("ordinary time-out limit wrong");
	a_status_ends: assert property (@(posedge clk) disable iff (rst)
		await_reg && !await_rtrt_reg && word_sync_mid && !sync_is_data
		|=> !await_reg && !timeout_reg)
		else $error("status sync did not end wait");
	a_rtrt_hold: assert property (@(posedge clk) disable iff (rst)
		await_reg && await_rtrt_reg && !sync_is_data &&
		resp_count + 1'b1 < resp_limit |=> await_reg)
		else $error("RT-RT wait ended by non-data sync");
	a_rtrt_allow: assert property (@(posedge clk) disable iff (rst)
		await_rtrt_reg |-> resp_limit >= timeout_limit(to_sel, 1'b0) +
		TW'(monitor_cfg_pkg::RTRT_ALLOW_CYC))
		else $error("RT-RT allowance missing");
	a_stop_taken: assert property (@(posedge clk) disable iff (rst)
		stop_take && state_reg == monitor_cfg_pkg::ST_RUN && msg_active
		|=> stop_pending ##1 stop_pending)
		else $error("packet stop not taken");
	a_msg_hold: assert property (@(posedge clk) disable iff (rst)
		state_reg == monitor_cfg_pkg::ST_DRAIN && msg_active |=> !close_reg)
		else $error("packet closed during message");
	a_reopen: assert property (@(posedge clk) disable iff (rst)
		close_reg |=> open_reg && !close_reg)
		else $error("new packet not started");
	a_gap_flag: assert property (@(posedge clk) disable iff (rst)
		gap_short |=> gapv_reg && fmt_reg)
		else $error("short gap not flagged");
	a_gap_off: assert property (@(posedge clk) disable iff (rst)
		!gap_en |=> !gapv_reg)
		else $error("gap flagged while disabled");
	a_type_code: assert property (@(posedge clk) disable iff (rst)
		!htd && ver_sel == 2'h0 |=> dtype_reg == 8'h04 && dvalid_reg)
		else $error("header type code wrong");
	a_htd_gate: assert property (@(posedge clk) disable iff (rst)
		htd |=> !dvalid_reg)
		else $error("header type valid while disabled");
	a_stop_reads: assert property (@(posedge clk) disable iff (rst)
		rvalid_reg |-> !rdata_reg[monitor_cfg_pkg::STOP_BIT])
		else $error("stop bit read back as one");

endmodule : packet_monitor_config

// >>> tb/bus_traffic_model.sv
`timescale 1ns/1ps
module bus_traffic_model (
	input wire logic clk,
	input wire logic parity_req,
	input wire logic sync_req,
	input wire logic msg_req,
	input wire logic arg_a,
	input wire logic arg_b,
	output logic msg_active,
	output logic msg_start,
	output logic word_parity_mid,
	output logic parity_word_is_command,
	output logic cmd_is_rtrt,
	output logic word_sync_mid,
	output logic sync_is_data
);
	////////////////////////////////////////////////////////////////////////
	// Word events; qualifiers show the inverse outside the event cycle
	logic act_reg = 1'b0;

	// Message level holds what the last message event set
	always @(posedge clk)
	begin
		if (msg_req)
			act_reg <= arg_a;
	end

	assign msg_active = msg_req ? arg_a : act_reg;
	assign msg_start = msg_req && arg_a;
	assign word_parity_mid = parity_req;
	assign parity_word_is_command = parity_req ? arg_a : !arg_a;
	assign cmd_is_rtrt = parity_req ? arg_b : !arg_b;
	assign word_sync_mid = sync_req;
	assign sync_is_data = sync_req ? arg_a : !arg_a;
endmodule : bus_traffic_model

// >>> tb/packet_monitor_config_tb_top.sv
`timescale 1ns/1ps
module packet_monitor_config_tb_top;
	localparam int TL[4] = '{20, 25, 40, 60};
	localparam int RL[4] = '{10020, 10025, 10040, 10060};
	localparam logic [15:0] ROWS[6][3] = '{
		'{16'h0000, 16'h0000, 16'h0104}, '{16'h4400, 16'h4400, 16'h0101},
		'{16'h8900, 16'h8900, 16'h0102}, '{16'hce00, 16'hce00, 16'h0103},
		'{16'hffff, 16'hdf08, 16'h0000}, '{16'h1308, 16'h1308, 16'h0000}};
	logic clk, rst, host_wr, host_rd, packet_recording_monitor;
	logic [15:0] host_addr, host_wdata, host_rdata, v, e;
	logic [7:0] header_data_type;
	logic [1:0] no_response_timeout_select, time_tag_select;
	logic host_rdata_valid, gap_check_enable, header_trailer_disable;
	logic header_type_valid, no_response_timeout, gap_violation;
	logic format_error, stop_pending, packet_close, packet_open;
	logic msg_active, msg_start, word_parity_mid, parity_word_is_command;
	logic cmd_is_rtrt, word_sync_mid, sync_is_data;
	logic parity_req, sync_req, msg_req, arg_a, arg_b;
	int bad_count, check_count, n;

	packet_monitor_config #(.TO_CYC_00(TL[0]), .TO_CYC_01(TL[1]),
		.TO_CYC_10(TL[2]), .TO_CYC_11(TL[3]), .RTRT_CYC_00(RL[0]),
		.RTRT_CYC_01(RL[1]), .RTRT_CYC_10(RL[2]), .RTRT_CYC_11(RL[3]))
	i_packet_monitor_config (.clk(clk), .rst(rst), .host_wr(host_wr),
		.host_rd(host_rd), .host_addr(host_addr), .host_wdata(host_wdata),
		.host_rdata(host_rdata), .host_rdata_valid(host_rdata_valid),
		.packet_recording_monitor(packet_recording_monitor),
		.msg_active(msg_active), .msg_start(msg_start),
		.word_parity_mid(word_parity_mid),
		.parity_word_is_command(parity_word_is_command),
		.cmd_is_rtrt(cmd_is_rtrt), .word_sync_mid(word_sync_mid),
		.sync_is_data(sync_is_data),
		.no_response_timeout_select(no_response_timeout_select),
		.gap_check_enable(gap_check_enable),
		.time_tag_select(time_tag_select),
		.header_trailer_disable(header_trailer_disable),
		.header_data_type(header_data_type),
		.header_type_valid(header_type_valid),
		.no_response_timeout(no_response_timeout),
		.gap_violation(gap_violation), .format_error(format_error),
		.stop_pending(stop_pending), .packet_close(packet_close),
		.packet_open(packet_open));
	bus_traffic_model i_bus_traffic_model (.clk(clk),
		.parity_req(parity_req), .sync_req(sync_req), .msg_req(msg_req),
		.arg_a(arg_a), .arg_b(arg_b), .msg_active(msg_active),
		.msg_start(msg_start), .word_parity_mid(word_parity_mid),
		.parity_word_is_command(parity_word_is_command),
		.cmd_is_rtrt(cmd_is_rtrt), .word_sync_mid(word_sync_mid),
		.sync_is_data(sync_is_data));

	////////////////////////////////////////////////////////////////////////
	// Host access and checking
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp)
		begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge clk);
		#1;
		host_wr = 1'b1;
		host_addr = a;
		host_wdata = d;
		@(posedge clk);
		#1;
		host_wr = 1'b0;
	endtask : wr
	task automatic rd(input logic [15:0] a);
		@(posedge clk);
		#1;
		host_rd = 1'b1;
		host_addr = a;
		@(posedge clk);
		#1;
		host_rd = 1'b0;
		chk({15'h0, host_rdata_valid}, 16'h0001);
		v = host_rdata;
	endtask : rd
	task automatic tick(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask : tick
	// Bus word and message events, one cycle each
	task automatic parity(input logic cmd, input logic rtrt);
		@(posedge clk);
		#1;
		parity_req = 1'b1;
		arg_a = cmd;
		arg_b = rtrt;
		@(posedge clk);
		#1;
		parity_req = 1'b0;
	endtask : parity
	task automatic sync(input logic dat);
		@(posedge clk);
		#1;
		sync_req = 1'b1;
		arg_a = dat;
		@(posedge clk);
		#1;
		sync_req = 1'b0;
	endtask : sync
	task automatic msg(input logic act);
		@(posedge clk);
		#1;
		msg_req = 1'b1;
		arg_a = act;
		@(posedge clk);
		#1;
		msg_req = 1'b0;
	endtask : msg
	task automatic tmo(input int lim);
		n = 0;
		while (no_response_timeout !== 1'b1 && n < lim + 10)
		begin
			tick(1);
			n++;
		end
		chk({15'h0, n >= lim - 1 && n <= lim + 2}, 16'h0001);
	endtask : tmo
	task automatic results();
		if (bad_count == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : results

	////////////////////////////////////////////////////////////////////////
	// Stimulus
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial
	begin
		#240000;
		bad_count++;
		results();
	end
	initial
	begin
		{rst, host_wr, host_rd, packet_recording_monitor} = 4'hf;
		{host_wr, host_rd, packet_recording_monitor} = 3'h0;
		{parity_req, sync_req, msg_req, arg_a, arg_b} = 5'h00;
		host_addr = 16'h0000;
		host_wdata = 16'h0000;
		repeat (12) @(posedge clk);
		#1;
		rst = 1'b0;
		rd(16'h0029);
		chk(v, monitor_cfg_pkg::CFG_RESET);
		chk({7'h0, header_type_valid, header_data_type}, 16'h0102);
		for (int i = 0; i < 6; i++)
		begin
			e = ROWS[i][1];
			wr(16'h0029, ROWS[i][0]);
			rd(16'h0029);
			chk(v, e);
			chk({7'h0, header_type_valid, header_data_type}, ROWS[i][2]);
			chk({10'h0, no_response_timeout_select, gap_check_enable,
				time_tag_select, header_trailer_disable},
				{10'h0, e[15:14], e[12], e[9:8], e[3]});
		end
		wr(16'h0028, 16'hffff);
		rd(16'h0028);
		chk(v, 16'h0000);
		rd(16'h0029);
		chk(v, ROWS[5][1]);
		for (int c = 0; c < 4; c++)
		begin
			wr(16'h0029, {c[1:0], 14'h0});
			parity(1'b1, 1'b0);
			sync(1'b1);
			tmo(TL[c]);
			parity(1'b1, 1'b1);
			sync(1'b0);
			tmo(RL[c]);
		end
		parity(1'b1, 1'b0);
		tick(5);
		sync(1'b0);
		n = 0;
		repeat (TL[3] + 10)
		begin
			tick(1);
			if (no_response_timeout !== 1'b0)
				n++;
		end
		chk({15'h0, n == 0}, 16'h0001);
		wr(16'h0029, 16'h1000);
		msg(1'b1);
		parity(1'b0, 1'b0);
		tick(8);
		sync(1'b1);
		chk({14'h0, gap_violation, format_error}, 16'h0003);
		msg(1'b1);
		parity(1'b0, 1'b0);
		tick(1002);
		sync(1'b1);
		chk({14'h0, gap_violation, format_error}, 16'h0000);
		wr(16'h0029, 16'h0800);
		parity(1'b0, 1'b0);
		tick(8);
		sync(1'b1);
		chk({14'h0, gap_violation, format_error}, 16'h0000);
		wr(16'h0029, 16'h2800);
		tick(4);
		chk({14'h0, stop_pending, packet_close}, 16'h0000);
		packet_recording_monitor = 1'b1;
		wr(16'h0029, 16'h0800);
		tick(4);
		chk({14'h0, stop_pending, packet_close}, 16'h0000);
		wr(16'h0029, 16'h2800);
		tick(6);
		chk({14'h0, stop_pending, packet_close}, 16'h0002);
		rd(16'h0029);
		chk(v, 16'h0800);
		msg(1'b0);
		n = 0;
		while (packet_close !== 1'b1 && n < 10)
		begin
			tick(1);
			n++;
		end
		chk({15'h0, packet_close}, 16'h0001);
		tick(1);
		chk({14'h0, packet_open, stop_pending}, 16'h0002);
		results();
	end
endmodule : packet_monitor_config_tb_top
